/* File: hw/tsq_pkg.sv */
// Constants, types and register map of the trigger and setup sequencer.
// Behaviour
// - Trigger copies setup one above step pointer.
// - Triggers ignored until trigger enable command.
// - Source external pulse or GET/execute/talk; default external.
// - Only the picked trigger source acts.
// - Trigger during transfer dropped, lamp, overrun cause.
// - After transfer time, triggers accepted again.
// - Trigger before settling ends flags not-settled.
// - Poll status shows ready and settle done.
// - Make-before-break: close new, then open old.
// - Break-before-make: open old, then close new.
// - Each intermediate setup adds one transfer and one relay settle.
// - Both row kinds: four phases, settle each.
// - External trigger edge chosen by edge command.
// - Settle done polarity set by polarity command.
// - Settle done after relay plus programmed settle.
// - Reset repeats power-up setup without self-check.
// - Loop error at reset forces stand-alone.
// - Address default 18; 0-30 alone, 31-60 master.
// - Crosspoint commands hit relays only at pointer zero.
// - Commands are letters with options, parsed in turn.
// - Erase opens setup; shut closes; release opens points.
// - Trigger in programmed settle runs but lights lamp.
package tsq_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned US_PER_S = 1_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned XFER_US = 100;
    localparam int unsigned CYC_XFER = XFER_US * (CLK_HZ / US_PER_S);
    localparam int unsigned RELAY_MS = 3;
    localparam int unsigned CYC_RELAY = RELAY_MS * CYC_PER_MS;
    // ----------------------------------------
    // Register offsets and fields
    // ----------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_SETTLE = 8'h04;
    localparam logic [7:0] ADDR_ROWS = 8'h08;
    localparam logic [7:0] ADDR_PTR = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_ERR = 8'h14;
    localparam logic [7:0] ADDR_RELAY = 8'h18;
    localparam int unsigned LET_LSB = 0;
    localparam int unsigned OPT1_LSB = 8;
    localparam int unsigned OPT2_LSB = 16;
    localparam int unsigned MB_LSB = 0;
    localparam int unsigned BM_LSB = 8;
    localparam int unsigned STEP_LSB = 8;
    localparam int unsigned ST_READY = 0;
    localparam int unsigned ST_SETTLED = 1;
    localparam int unsigned ST_FAULT = 2;
    localparam int unsigned ERR_OVR = 0;
    localparam int unsigned ERR_NSET = 1;
    // ----------------------------------------
    // Command letters
    // ----------------------------------------
    localparam logic [7:0] CMD_ENABLE = 8'h46;
    localparam logic [7:0] CMD_SOURCE = 8'h54;
    localparam logic [7:0] CMD_EDGE = 8'h41;
    localparam logic [7:0] CMD_POL = 8'h42;
    localparam logic [7:0] CMD_ERASE = 8'h50;
    localparam logic [7:0] CMD_SHUT = 8'h43;
    localparam logic [7:0] CMD_RELEASE = 8'h4E;
    // ----------------------------------------
    // Address switch limits
    // ----------------------------------------
    localparam logic [5:0] DEF_BUS_ADDR = 6'h12;
    localparam logic [5:0] SA_MAX = 6'h1E;
    localparam logic [5:0] MS_MIN = 6'h1F;
    localparam logic [5:0] MS_MAX = 6'h3C;
    localparam logic [5:0] MS_OFFSET = 6'h1E;
    typedef enum logic [1:0] {SRC_EXT, SRC_GET, SRC_EXEC, SRC_TALK} tsq_src_e;
    typedef enum {S_IDLE, S_XFER, S_MID, S_RLY, S_PROG} tsq_state_e;
endpackage

/* File: hw/tsq_top.sv */
// Trigger handling and relay setup sequencing for the crosspoint matrix.
`timescale 1ns/1ps
module tsq_top #(
    parameter int unsigned ROWS = 4,
    parameter int unsigned COLS = 8,
    parameter int unsigned SETUPS = 16,
    parameter int unsigned CYC_MS = tsq_pkg::CYC_PER_MS,
    parameter int unsigned RELAY_CYC = tsq_pkg::CYC_RELAY
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic ext_stim_jack,
    input wire logic get_evt,
    input wire logic exec_evt,
    input wire logic talk_evt,
    input wire logic [5:0] addr_sw,
    input wire logic master_sw,
    input wire logic loop_err,
    output logic [ROWS*COLS-1:0] relay_out,
    output logic trigger_ready,
    output logic settle_done_out,
    output logic fault_lamp,
    output logic [7:0] poll_status,
    output logic [5:0] bus_addr,
    output logic master_active
);
    import tsq_pkg::*;

    localparam int unsigned NX = ROWS * COLS;
    localparam int unsigned PW = $clog2(SETUPS);
    localparam int unsigned RW = $clog2(ROWS);
    localparam int unsigned CW = $clog2(COLS);
    localparam int unsigned TW = $clog2(RELAY_CYC + CYC_XFER + 1);
    localparam int unsigned MW = $clog2(CYC_MS + 1);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_ff1_r; // First stage, read only by the second.
    logic rst_ff2_r; // Synchronised reset used everywhere.
    logic rstn_s;

    // Asynchronous assert, synchronous release, so no flop leaves
    // reset on a different edge than its neighbours.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_ff1_r <= 1'b0;
            rst_ff2_r <= 1'b0;
        end else begin
            rst_ff1_r <= 1'b1;
            rst_ff2_r <= rst_ff1_r;
        end
    end
    assign rstn_s = rst_ff2_r;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic trig_en_r; // Triggers enabled.
    tsq_src_e src_r; // Selected trigger source.
    logic rise_r; // External edge: one for rising.
    logic pol_r; // Settle done output high-true when one.
    logic [15:0] settle_ms_r; // Programmed settling time in ms.
    logic [ROWS-1:0] mb_r; // Make-before-break rows.
    logic [ROWS-1:0] bm_r; // Break-before-make rows.
    logic [PW-1:0] edit_r; // Edit pointer.
    logic [1:0] err_r; // Error cause bits.
    logic fault_r; // Fault lamp.

    logic cmd_we;
    logic [7:0] let_w;
    logic [7:0] opt1_w;
    logic [7:0] opt2_w;
    logic [ROWS-1:0] mb_w;
    logic [ROWS-1:0] bm_w;

    assign cmd_we = wr && (addr == ADDR_CMD);
    assign let_w = wdata[LET_LSB +: 8];
    assign opt1_w = wdata[OPT1_LSB +: 8];
    assign opt2_w = wdata[OPT2_LSB +: 8];
    assign mb_w = wdata[MB_LSB +: ROWS];
    // A row chosen for both kinds keeps make-before-break only.
    assign bm_w = wdata[BM_LSB +: ROWS] & ~mb_w;

    // Each command word carries one letter; a string of commands is
    // issued as successive writes and decoded strictly in order.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            trig_en_r <= 1'b0;
            src_r <= SRC_EXT;
            rise_r <= 1'b0;
            pol_r <= 1'b1;
        end else if (cmd_we) begin
            unique case (let_w)
                CMD_ENABLE: trig_en_r <= opt1_w[0];
                CMD_SOURCE: src_r <= tsq_src_e'(opt1_w[1:0]);
                CMD_EDGE: rise_r <= opt1_w[0];
                CMD_POL: pol_r <= opt1_w[0];
                default: ; // Other letters are handled elsewhere or ignored.
            endcase
        end
    end

    // Switching parameters and the edit pointer.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            settle_ms_r <= 16'h0000;
            mb_r <= '0;
            bm_r <= '0;
            edit_r <= '0;
        end else if (wr) begin
            if (addr == ADDR_SETTLE) begin
                settle_ms_r <= wdata[15:0];
            end
            if (addr == ADDR_ROWS) begin
                mb_r <= mb_w;
                bm_r <= bm_w;
            end
            if (addr == ADDR_PTR) begin
                edit_r <= wdata[PW-1:0];
            end
        end
    end

    // ----------------------------------------
    // Trigger sources
    // ----------------------------------------
    logic ext_s1_r; // Read only by the second stage.
    logic ext_s2_r;
    logic ext_s3_r;
    logic ext_lvl_r; // Filtered level of the jack.
    logic ext_edge;
    logic trig;

    // Three stages; a level change is believed once stages two and
    // three agree, which also rejects a one-cycle glitch.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            ext_s1_r <= 1'b1;
            ext_s2_r <= 1'b1;
            ext_s3_r <= 1'b1;
            ext_lvl_r <= 1'b1;
        end else begin
            ext_s1_r <= ext_stim_jack;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (ext_s2_r == ext_s3_r) begin
                ext_lvl_r <= ext_s3_r;
            end
        end
    end

    assign ext_edge = (ext_s2_r == ext_s3_r) && (ext_s3_r != ext_lvl_r)
                      && (ext_s3_r == rise_r);

    // Only the selected source can fire, and only while enabled.
    always_comb begin
        unique case (src_r)
            SRC_EXT: trig = ext_edge;
            SRC_GET: trig = get_evt;
            SRC_EXEC: trig = exec_evt;
            SRC_TALK: trig = talk_evt;
        endcase
        trig = trig && trig_en_r;
    end

    // ----------------------------------------
    // Setup memory and row masks
    // ----------------------------------------
    logic [NX-1:0] mem_r [SETUPS]; // Stored setups; entry zero unused.
    logic [NX-1:0] mbx;
    logic [NX-1:0] bmx;
    logic [RW+CW-1:0] xp_w; // Crosspoint bit named by a command.
    logic xp_cmd;
    logic [PW-1:0] erase_w;

    genvar gr;
    generate
        for (gr = 0; gr < ROWS; gr++) begin : g_row
            assign mbx[gr*COLS +: COLS] = {COLS{mb_r[gr]}};
            assign bmx[gr*COLS +: COLS] = {COLS{bm_r[gr]}};
        end
    endgenerate

    assign xp_w = {opt1_w[RW-1:0], opt2_w[CW-1:0]};
    assign xp_cmd = cmd_we && ((let_w == CMD_SHUT) || (let_w == CMD_RELEASE));
    assign erase_w = opt1_w[PW-1:0];

    // Shut and release with a nonzero edit pointer edit memory only; the
    // relays are left alone so a setup can be prepared off-line.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            for (int i = 0; i < SETUPS; i++) begin
                mem_r[i] <= '0;
            end
        end else if (cmd_we) begin
            if ((let_w == CMD_ERASE) && (erase_w != '0)) begin
                mem_r[erase_w] <= '0;
            end
            if (xp_cmd && (edit_r != '0)) begin
                mem_r[edit_r][xp_w] <= (let_w == CMD_SHUT);
            end
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    tsq_state_e st_r;
    logic [TW-1:0] cnt_r; // Transfer and relay settle timer.
    logic [MW-1:0] ms_cnt_r; // Millisecond divider.
    logic [15:0] ms_left_r; // Programmed settle remaining.
    logic [NX-1:0] relay_r;
    logic [NX-1:0] cur_r; // Relays before the change.
    logic [NX-1:0] tgt_r; // Final setup.
    logic [PW-1:0] step_r; // Relay step pointer.
    logic [PW-1:0] step_nxt;
    logic [3:0] ph_en_r; // Enabled phases.
    logic [1:0] ph_r; // Phase in progress.
    logic [1:0] ph_nxt;
    logic [3:0] en_w;
    logic [NX-1:0] s1;
    logic [NX-1:0] s2;
    logic [NX-1:0] s3;
    logic [NX-1:0] stage;
    logic accept;
    logic busy;

    assign step_nxt = (step_r == PW'(SETUPS - 1)) ? PW'(1) : step_r + PW'(1);
    // Phase one needs break rows, two needs make rows, three needs
    // both; the last phase always runs.
    assign en_w = {1'b1, (|mb_r) && (|bm_r), |mb_r, |bm_r};
    assign busy = (st_r == S_XFER) || (st_r == S_MID);
    assign accept = trig && !busy;

    // Intermediate setups chained from the present relays.
    assign s1 = cur_r & ~bmx;
    assign s2 = s1 | (tgt_r & mbx);
    assign s3 = (s2 & ~mbx) | (tgt_r & mbx);

    always_comb begin
        unique case (ph_r)
            2'd0: stage = s1;
            2'd1: stage = s2;
            2'd2: stage = s3;
            2'd3: stage = tgt_r;
        endcase
    end

    // Next enabled phase after the current one.
    always_comb begin
        ph_nxt = 2'd3;
        for (int k = 2; k >= 0; k--) begin
            if ((k > ph_r) && ph_en_r[k]) begin
                ph_nxt = 2'(k);
            end
        end
    end

    // Main flow: a transfer and one relay settle per intermediate
    // setup, then a transfer, relay settle and programmed settle for the last.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            st_r <= S_IDLE;
            cnt_r <= '0;
            ms_cnt_r <= '0;
            ms_left_r <= 16'h0000;
            relay_r <= '0;
            cur_r <= '0;
            tgt_r <= '0;
            step_r <= '0;
            ph_en_r <= 4'h8;
            ph_r <= 2'd3;
        end else begin
            // Direct relay edits at pointer zero.
            if (cmd_we && (let_w == CMD_ERASE) && (erase_w == '0)) begin
                relay_r <= '0;
            end
            if (xp_cmd && (edit_r == '0)) begin
                relay_r[xp_w] <= (let_w == CMD_SHUT);
            end
            if (accept) begin
                cur_r <= relay_r;
                tgt_r <= mem_r[step_nxt];
                step_r <= step_nxt;
                ph_en_r <= en_w;
                ph_r <= en_w[0] ? 2'd0 : (en_w[1] ? 2'd1 : 2'd3);
                cnt_r <= TW'(CYC_XFER - 1);
                st_r <= S_XFER;
            end else begin
                unique case (st_r)
                    S_IDLE: ;
                    S_XFER: begin
                        if (cnt_r == '0) begin
                            relay_r <= stage;
                            cnt_r <= TW'(RELAY_CYC - 1);
                            st_r <= (ph_r == 2'd3) ? S_RLY : S_MID;
                        end else begin
                            cnt_r <= cnt_r - TW'(1);
                        end
                    end
                    S_MID: begin
                        // One full relay settle for this intermediate.
                        if (cnt_r == '0) begin
                            ph_r <= ph_nxt;
                            cnt_r <= TW'(CYC_XFER - 1);
                            st_r <= S_XFER;
                        end else begin
                            cnt_r <= cnt_r - TW'(1);
                        end
                    end
                    S_RLY: begin
                        if (cnt_r == '0) begin
                            ms_cnt_r <= MW'(CYC_MS - 1);
                            ms_left_r <= settle_ms_r;
                            st_r <= (settle_ms_r == 16'h0000) ? S_IDLE : S_PROG;
                        end else begin
                            cnt_r <= cnt_r - TW'(1);
                        end
                    end
                    S_PROG: begin
                        // Millisecond enable pulse counts the programmed time.
                        if (ms_cnt_r == '0) begin
                            ms_cnt_r <= MW'(CYC_MS - 1);
                            ms_left_r <= ms_left_r - 16'h0001;
                            if (ms_left_r == 16'h0001) begin
                                st_r <= S_IDLE;
                            end
                        end else begin
                            ms_cnt_r <= ms_cnt_r - MW'(1);
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Errors and fault lamp
    // ----------------------------------------
    logic err_rd;
    logic ovr_set;
    logic nset_set;

    assign err_rd = rd && (addr == ADDR_ERR);
    assign ovr_set = trig && busy;
    assign nset_set = trig && ((st_r == S_RLY) || (st_r == S_PROG));

    // Reading the cause clears it; a new error in that cycle wins so
    // that no event slips between the read and the clear.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            err_r <= 2'b00;
            fault_r <= 1'b0;
        end else begin
            if (err_rd) begin
                err_r <= 2'b00;
                fault_r <= 1'b0;
            end
            if (ovr_set) begin
                err_r[ERR_OVR] <= 1'b1;
            end
            if (nset_set) begin
                err_r[ERR_NSET] <= 1'b1;
            end
            if (ovr_set || nset_set) begin
                fault_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    logic ready_w;
    logic done_w;
    logic ready_r;
    logic sd_r;
    logic [7:0] poll_r;

    assign ready_w = !busy && !accept;
    assign done_w = (st_r == S_IDLE) && !accept;

    // Output flops; settle done gets its programmed polarity here.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            ready_r <= 1'b1;
            sd_r <= 1'b1;
            poll_r <= 8'h03;
        end else begin
            ready_r <= ready_w;
            sd_r <= pol_r ? done_w : !done_w;
            poll_r <= '0;
            poll_r[ST_READY] <= ready_w;
            poll_r[ST_SETTLED] <= done_w;
            poll_r[ST_FAULT] <= fault_r || ovr_set || nset_set;
        end
    end

    // ----------------------------------------
    // Address straps
    // ----------------------------------------
    logic strap_done_r; // Straps caught once after each reset.
    logic [5:0] addr_r;
    logic master_r;
    logic sa_ok;
    logic ms_ok;

    assign sa_ok = addr_sw <= SA_MAX;
    assign ms_ok = (addr_sw >= MS_MIN) && (addr_sw <= MS_MAX);

    // Straps are read on the first edge after release, so a reset
    // key press re-runs the same start-up as power-up.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            strap_done_r <= 1'b0;
            addr_r <= DEF_BUS_ADDR;
            master_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            if (master_sw && ms_ok) begin
                addr_r <= addr_sw - MS_OFFSET;
                master_r <= !loop_err;
            end else if (!master_sw && sa_ok) begin
                addr_r <= addr_sw;
            end else begin
                addr_r <= DEF_BUS_ADDR;
            end
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    logic [31:0] rdata_r;

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk or negedge rstn_s) begin
        if (!rstn_s) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= '0;
            if (rd) begin
                unique case (addr)
                    ADDR_SETTLE: rdata_r <= {16'h0000, settle_ms_r};
                    ADDR_ROWS: begin
                        rdata_r[MB_LSB +: ROWS] <= mb_r;
                        rdata_r[BM_LSB +: ROWS] <= bm_r;
                    end
                    ADDR_PTR: begin
                        rdata_r[PW-1:0] <= edit_r;
                        rdata_r[STEP_LSB +: PW] <= step_r;
                    end
                    ADDR_STAT: rdata_r <= {24'h000000, poll_r};
                    ADDR_ERR: rdata_r <= {30'h00000000, err_r};
                    ADDR_RELAY: rdata_r <= 32'(relay_r);
                    default: rdata_r <= '0; // Unmapped reads as zero.
                endcase
            end
        end
    end

    assign rdata = rdata_r;
    assign relay_out = relay_r;
    assign trigger_ready = ready_r;
    assign settle_done_out = sd_r;
    assign fault_lamp = fault_r;
    assign poll_status = poll_r;
    assign bus_addr = addr_r;
    assign master_active = master_r;
endmodule // tsq_top

/* File: tb/tsq_properties.sv */
// Port checks for the trigger sequencer.
`timescale 1ns/1ps
module tsq_checker
    import tsq_pkg::*;
#(
    parameter int unsigned RELAY_CYC = CYC_RELAY
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic trigger_ready,
    input wire logic [7:0] poll_status,
    input wire logic [5:0] bus_addr,
    input wire logic master_active,
    input wire logic loop_err
);
    // Longest busy span: four transfers and three relay settles.
    localparam int unsigned BUSY_MAX = 4 * CYC_XFER + 3 * RELAY_CYC + 2;
    logic [15:0] busy_r; // Cycles spent not ready.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // A counter, since the spans are too long to unroll.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) busy_r <= 16'h0000;
        else busy_r <= trigger_ready ? 16'h0000 : busy_r + 16'h0001;
    end
    sequence s_busy;
        !trigger_ready [*8];
    endsequence
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0) else $error("stray read data");
    a_busy_hold: assert property ($fell(trigger_ready) |-> s_busy) else $error("ready early");
    a_busy_bound: assert property (busy_r <= BUSY_MAX) else $error("ready late");
    a_poll_ready: assert property ($rose(trigger_ready) |-> poll_status[ST_READY])
        else $error("poll ready bit");
    a_settle_order: assert property ($rose(poll_status[ST_SETTLED]) |-> trigger_ready)
        else $error("settled before ready");
    a_settle_gap: assert property ($rose(trigger_ready) |-> !poll_status[ST_SETTLED] [*6])
        else $error("relay settle skipped");
    a_addr_range: assert property (bus_addr <= SA_MAX) else $error("bus address range");
    a_loop_alone: assert property (loop_err |-> !master_active) else $error("master kept");
endmodule // tsq_checker
bind tsq_top tsq_checker #(.RELAY_CYC(RELAY_CYC)) u_chk (.clk, .resetn, .rd, .rdata,
    .trigger_ready, .poll_status, .bus_addr, .master_active, .loop_err);

/* File: tb/tsq_ctrl_model.sv */
// Bus controller and external pulse source model.
`timescale 1ns/1ps
module tsq_ctrl_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] kind,
    output logic get_evt,
    output logic exec_evt,
    output logic talk_evt,
    output logic ext_pin
);
    logic [3:0] hot_r = 4'h0; // One-hot bus event.
    logic [3:0] low_r = 4'h0; // Cycles left of the low pulse.
    // Bus events last one cycle; the pin idles high between pulses.
    always_ff @(posedge clk) begin
        hot_r <= go ? 4'h1 << kind : 4'h0;
        low_r <= (go && kind == 2'h0) ? 4'h8 : low_r - {3'h0, low_r != 4'h0};
    end
    assign get_evt = hot_r[1];
    assign exec_evt = hot_r[2];
    assign talk_evt = hot_r[3];
    assign ext_pin = low_r == 4'h0;
endmodule // tsq_ctrl_model

/* File: tb/tb_trigger_setup_sequencer.sv */
// Self-checking bench for the trigger sequencer.
`timescale 1ns/1ps
module tb_trigger_setup_sequencer;
    import tsq_pkg::*;
    logic clk, resetn, wr, rd, go, ext_stim_jack, get_evt, exec_evt, talk_evt, rd_seen;
    logic trigger_ready, settle_done_out, fault_lamp, master_sw, loop_err;
    logic [1:0] kind;
    logic [7:0] addr, col, poll_status;
    logic [5:0] bus_addr, addr_sw = 6'h05;
    logic [31:0] wdata, rdata, relay_out, exp_q[$];
    logic [31:0] rows_t[4] = '{32'h0, 32'h1, 32'h200, 32'h201}; // Row modes.
    int ph_t[4] = '{1, 2, 2, 4}; // Phases of each mode.
    int failures = 0, tests_run = 0, low_n, n, seed;
    tsq_top #(.CYC_MS(4), .RELAY_CYC(8)) uut (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
        .ext_stim_jack, .get_evt, .exec_evt, .talk_evt, .addr_sw, .master_sw,
        .loop_err, .relay_out, .trigger_ready, .settle_done_out, .fault_lamp,
        .poll_status, .bus_addr, .master_active());
    tsq_ctrl_model ctrl (.clk, .go, .kind, .get_evt, .exec_evt, .talk_evt,
        .ext_pin(ext_stim_jack));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Read data and busy time are judged mid-cycle, clear of the edge.
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen === 1'b1) chk("rdata", exp_q.pop_front(), rdata);
        if (trigger_ready === 1'b0) low_n++;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic fire(input logic [1:0] k);
        @(posedge clk);
        kind <= k;
        go <= 1'b1;
        low_n = 0;
        @(posedge clk);
        go <= 1'b0;
    endtask
    // Waits for the fall, if any, then for ready again; returns busy cycles.
    task automatic wait_ready(output int cnt);
        int i;
        for (i = 0; i < 20 && trigger_ready === 1'b1; i++) @(negedge clk);
        for (i = 0; i < 9000 && trigger_ready !== 1'b1; i++) @(negedge clk);
        if (i == 9000) failures++;
        cnt = low_n;
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {wr, rd, go, kind, addr, wdata, master_sw, loop_err} = '0;
        seed = $urandom(32'hF010AACD);
        resetn = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("bus_addr", 32'h5, {26'h0, bus_addr});
        reg_rd(ADDR_STAT, 32'h3);
        reg_rd(8'h1C, 32'h0);
        col = 8'($urandom % 8);
        reg_wr(ADDR_PTR, 32'h1);
        reg_wr(ADDR_CMD, {8'h0, col, 8'h0, CMD_SHUT});
        reg_wr(ADDR_PTR, 32'h0);
        reg_wr(ADDR_CMD, {8'h0, col, 8'h3, CMD_SHUT});
        reg_rd(ADDR_RELAY, 32'h1 << (24 + col));
        reg_wr(ADDR_CMD, {8'h0, col, 8'h3, CMD_RELEASE});
        reg_rd(ADDR_RELAY, 32'h0);
        reg_wr(ADDR_CMD, {8'h0, col, 8'h3, CMD_SHUT});
        reg_wr(ADDR_CMD, {24'h0, CMD_ERASE});
        reg_rd(ADDR_RELAY, 32'h0);
        fire(2'h0);
        wait_ready(n);
        reg_rd(ADDR_PTR, 32'h0);
        $display("test edit done");
        reg_wr(ADDR_CMD, {16'h0, 8'h1, CMD_ENABLE});
        reg_wr(ADDR_CMD, {16'h0, 8'h1, CMD_SOURCE});
        reg_wr(ADDR_SETTLE, 32'h2);
        fire(2'h1);
        repeat (10) @(posedge clk);
        fire(2'h1);
        wait_ready(n);
        reg_rd(ADDR_RELAY, 32'h1 << col);
        fire(2'h1);
        wait_ready(n);
        chk("fault_lamp", 32'h1, {31'h0, fault_lamp});
        reg_rd(ADDR_ERR, 32'h3);
        reg_rd(ADDR_PTR, 32'h200);
        $display("test overrun done");
        for (int k = 0; k < 4; k++) begin
            reg_wr(ADDR_CMD, {16'h0, 8'(k), CMD_SOURCE});
            fire(2'(k + 1));
            wait_ready(n);
            repeat (40) @(posedge clk);
            fire(2'(k));
            wait_ready(n);
            reg_rd(ADDR_PTR, 32'(3 + k) << 8);
        end
        reg_rd(ADDR_ERR, 32'h0);
        $display("test sources done");
        reg_wr(ADDR_CMD, {16'h0, 8'h1, CMD_SOURCE});
        foreach (rows_t[m]) begin
            reg_wr(ADDR_ROWS, rows_t[m]);
            repeat (40) @(posedge clk);
            fire(2'h1);
            wait_ready(n);
            chk("busy", 32'(ph_t[m] * (CYC_XFER + 8) - 7), 32'(n));
        end
        repeat (100) @(posedge clk);
        chk("settle_out", 32'h1, {31'h0, settle_done_out});
        reg_wr(ADDR_CMD, {16'h0, 8'h0, CMD_POL});
        repeat (3) @(posedge clk);
        chk("settle_out", 32'h0, {31'h0, settle_done_out});
        addr_sw <= 6'h2A;
        {master_sw, loop_err} <= 2'b11;
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("bus_addr", 32'hC, {26'h0, bus_addr});
        $display("test rows done");
        test_done();
    end
    initial begin
        repeat (50000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule // tb_trigger_setup_sequencer
